/* common/lcmd_pkg.sv */
package lcmd_pkg;

  // group geometry
  localparam int NUM_CELLS   = 10;
  localparam int FIRST_CELL  = 0;
  localparam int SECOND_CELL = 1;
  localparam int LAST_CELL   = NUM_CELLS - 1;
  localparam int ADDR_W      = 4;
  localparam int DATA_W      = 32;
  localparam int LUT_W       = 16;
  localparam int HALF_LUT_W  = 8;
  localparam int SYNC_LINES  = 3;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] REG_CELL_CFG0 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_GLOBAL    = 4'hA;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hB;

  // per-cell configuration word
  localparam int F_LUT_LO       = 0;
  localparam int F_MODE_LO      = 16;
  localparam int F_FF_LO        = 18;
  localparam int F_BYPASS       = 20;
  localparam int F_C_FROM_CARRY = 21;
  localparam int F_ACLR_EN      = 22;
  localparam int F_ACLR_SEL_B   = 23;
  localparam int F_PRESET       = 24;
  localparam int F_CTRL_UPDN    = 25;
  localparam int F_CASC_EN      = 26;
  localparam int F_FAST_FB      = 27;
  localparam int F_LOAD_HOLD    = 28;
  localparam logic [DATA_W-1:0] CELL_CFG_MASK = 32'h1FFF_FFFF;
  localparam logic [DATA_W-1:0] CELL_CFG_RST  = 32'h0000_0000;

  // global word
  localparam int G_CHIP_RST_EN   = 0;
  localparam int G_CTRL_FROM_C0  = 1;
  localparam int G_TRI_OE_LO     = 16;
  localparam logic [DATA_W-1:0] GLOBAL_MASK = 32'h03FF_0003;
  localparam logic [DATA_W-1:0] GLOBAL_RST  = 32'h0000_0000;

  // status word
  localparam int S_OUT_LO = 0;
  localparam int S_CARRY  = 16;
  localparam int S_CASC   = 17;
  localparam int S_TRI    = 18;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

  // counter lookups, index {carry_in, control, q}
  localparam logic [HALF_LUT_W-1:0] CNT_UPDN_DATA  = 8'h5A;
  localparam logic [HALF_LUT_W-1:0] CNT_UPDN_CARRY = 8'h90;
  localparam logic [HALF_LUT_W-1:0] CNT_EN_DATA    = 8'h6A;
  localparam logic [HALF_LUT_W-1:0] CNT_EN_CARRY   = 8'h80;

  typedef enum logic [1:0] {
    LCMD_NORMAL  = 2'b00,
    LCMD_ARITH   = 2'b01,
    LCMD_COUNTER = 2'b11
  } lcmd_mode_t;

  typedef enum logic [1:0] {
    LCMD_FF_D  = 2'b00,
    LCMD_FF_T  = 2'b01,
    LCMD_FF_JK = 2'b11,
    LCMD_FF_SR = 2'b10
  } lcmd_ff_t;

endpackage

/* design/lcmd_cell_group.sv */
`timescale 1ns/1ns
module lcmd_cell_group (
  // clock and bus reset
  input  wire logic                              REF_CLK,
  input  wire logic                              RST_N,
  // avalon-mm slave
  input  wire logic [lcmd_pkg::ADDR_W-1:0]       AVS_ADDRESS,
  input  wire logic                              AVS_READ,
  input  wire logic                              AVS_WRITE,
  input  wire logic [lcmd_pkg::DATA_W-1:0]       AVS_WRITEDATA,
  output logic      [lcmd_pkg::DATA_W-1:0]       AVS_READDATA,
  output logic                                   AVS_WAITREQUEST,
  // cell data inputs
  input  wire logic [lcmd_pkg::NUM_CELLS-1:0]    CELL_IN_A,
  input  wire logic [lcmd_pkg::NUM_CELLS-1:0]    CELL_IN_B,
  input  wire logic [lcmd_pkg::NUM_CELLS-1:0]    CELL_IN_C,
  input  wire logic [lcmd_pkg::NUM_CELLS-1:0]    CELL_IN_D,
  // group-wide controls
  input  wire logic                              GROUP_CTRL_LINE_A_N,
  input  wire logic                              GROUP_CTRL_LINE_B_N,
  input  wire logic                              CHIP_RESET_N,
  input  wire logic                              GROUP_SYNC_CLEAR,
  input  wire logic                              GROUP_SYNC_LOAD,
  // chains from the previous group
  input  wire logic                              CARRY_IN,
  input  wire logic                              CASCADE_IN,
  // results
  output logic      [lcmd_pkg::NUM_CELLS-1:0]    CELL_OUT,
  output logic                                   CARRY_OUT,
  output logic                                   CASCADE_OUT,
  output logic                                   TRI_BUS_OUT
);

  localparam int NC     = lcmd_pkg::NUM_CELLS;
  localparam int SW     = 4 * lcmd_pkg::NUM_CELLS + 4;
  localparam int AW     = lcmd_pkg::ADDR_W;
  localparam int SYNC_N = lcmd_pkg::SYNC_LINES;

  logic [lcmd_pkg::DATA_W-1:0] cfg_r [NC];
  logic [lcmd_pkg::DATA_W-1:0] global_r;
  logic [lcmd_pkg::DATA_W-1:0] rd_word;
  logic [lcmd_pkg::DATA_W-1:0] status_word;
  logic                        ack_r;
  logic [SW-1:0]               sync_meta_r;
  logic [SW-1:0]               sync_r;
  logic [SYNC_N-1:0]           line_r;
  logic [NC-1:0]               in_a;
  logic [NC-1:0]               in_b;
  logic [NC-1:0]               in_c;
  logic [NC-1:0]               in_d;
  logic                        pin_sclr;
  logic                        pin_sload;
  logic                        carry_in_s;
  logic                        casc_in_s;
  logic                        sclr;
  logic                        sload;
  logic                        chip_clr;
  logic [NC-1:0]               carry_in;
  logic [NC-1:0]               carry_out;
  logic [NC-1:0]               casc_in;
  logic [NC-1:0]               casc_out;
  logic [NC-1:0]               cell_val;
  logic [NC-1:0]               cell_q;
  logic [NC-1:0]               aclr_n;
  logic [NC-1:0]               tri_oe;
  logic [NC-1:0]               tri_multi;
  logic                        tri_nxt;

  // bus slave: one wait cycle, answer on the second edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
    end
  end

  // status shows registered outputs, one cycle old
  // reads beyond the status word return zero
  always_comb begin
    status_word = lcmd_pkg::READ_UNMAPPED;
    status_word[lcmd_pkg::S_OUT_LO +: NC] = CELL_OUT;
    status_word[lcmd_pkg::S_CARRY] = CARRY_OUT;
    status_word[lcmd_pkg::S_CASC] = CASCADE_OUT;
    status_word[lcmd_pkg::S_TRI] = TRI_BUS_OUT;
    rd_word = lcmd_pkg::READ_UNMAPPED;
    if (AVS_ADDRESS < lcmd_pkg::REG_GLOBAL) begin
      rd_word = cfg_r[AVS_ADDRESS];
    end else if (AVS_ADDRESS == lcmd_pkg::REG_GLOBAL) begin
      rd_word = global_r;
    end else if (AVS_ADDRESS == lcmd_pkg::REG_STATUS) begin
      rd_word = status_word;
    end
  end

  // read data stands until the next read
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      AVS_READDATA <= lcmd_pkg::READ_UNMAPPED;
    end else if (AVS_READ && !ack_r) begin
      AVS_READDATA <= rd_word;
    end
  end

  // write lands on the edge that ends the wait
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      global_r <= lcmd_pkg::GLOBAL_RST;
    end else if (AVS_WRITE && ack_r && AVS_ADDRESS == lcmd_pkg::REG_GLOBAL) begin
      global_r <= AVS_WRITEDATA & lcmd_pkg::GLOBAL_MASK;
    end
  end

  // data pins: two flops before use
  // sync clear and load ride the same flops, so they stay aligned with data
  always_ff @(posedge REF_CLK) begin
    sync_meta_r <= {CARRY_IN, CASCADE_IN, GROUP_SYNC_CLEAR, GROUP_SYNC_LOAD,
                    CELL_IN_D, CELL_IN_C, CELL_IN_B, CELL_IN_A};
    sync_r      <= sync_meta_r;
  end

  assign in_a       = sync_r[0 +: NC];
  assign in_b       = sync_r[NC +: NC];
  assign in_c       = sync_r[2*NC +: NC];
  assign in_d       = sync_r[3*NC +: NC];
  assign pin_sload  = sync_r[4*NC];
  assign pin_sclr   = sync_r[4*NC+1];
  assign casc_in_s  = sync_r[4*NC+2];
  assign carry_in_s = sync_r[4*NC+3];

  // async lines: assert at once, release through two flops to avoid recovery hazards
  generate
    for (genvar j = 0; j < SYNC_N; j++) begin : g_line
      logic raw_n;
      logic meta_n_r;
      logic hold_n_r;

      assign raw_n = (j == 0) ? GROUP_CTRL_LINE_A_N :
                     (j == 1) ? GROUP_CTRL_LINE_B_N : CHIP_RESET_N;
      always_ff @(posedge REF_CLK or negedge raw_n) begin
        if (!raw_n) begin
          meta_n_r <= 1'b0;
          hold_n_r <= 1'b0;
        end else begin
          meta_n_r <= 1'b1;
          hold_n_r <= meta_n_r;
        end
      end
      // only the second flop is read past here
      assign line_r[j] = hold_n_r;
    end
  endgenerate

  assign chip_clr = global_r[lcmd_pkg::G_CHIP_RST_EN] & ~line_r[2];

  // first cell may source the group controls
  assign sclr  = global_r[lcmd_pkg::G_CTRL_FROM_C0] ? in_a[lcmd_pkg::FIRST_CELL] : pin_sclr;
  assign sload = global_r[lcmd_pkg::G_CTRL_FROM_C0] ? in_b[lcmd_pkg::FIRST_CELL] : pin_sload;

  generate
    for (genvar i = 0; i < NC; i++) begin : g_cell
      logic [lcmd_pkg::DATA_W-1:0]     cfg;
      logic [lcmd_pkg::LUT_W-1:0]      lut;
      lcmd_pkg::lcmd_mode_t            mode;
      lcmd_pkg::lcmd_ff_t              ff;
      logic                            st_r;
      logic                            st_nxt;
      logic                            d_val;
      logic                            ctrl;
      logic                            load_val;
      logic [2:0]                      idx3;
      logic [3:0]                      idx4;
      logic                            lut_c;

      assign cfg  = cfg_r[i];
      assign lut  = cfg[lcmd_pkg::F_LUT_LO +: lcmd_pkg::LUT_W];
      assign mode = lcmd_pkg::lcmd_mode_t'(cfg[lcmd_pkg::F_MODE_LO +: 2]);
      assign ff   = lcmd_pkg::lcmd_ff_t'(cfg[lcmd_pkg::F_FF_LO +: 2]);

      // per-cell config word, masked to its fields
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          cfg_r[i] <= lcmd_pkg::CELL_CFG_RST;
        end else if (AVS_WRITE && ack_r &&
                     AVS_ADDRESS == lcmd_pkg::REG_CELL_CFG0 + AW'(i)) begin
          cfg_r[i] <= AVS_WRITEDATA & lcmd_pkg::CELL_CFG_MASK;
        end
      end

      if (i == lcmd_pkg::FIRST_CELL) begin : g_first
        assign carry_in[i] = 1'b0;
        assign casc_in[i]  = 1'b1;
      end else if (i == lcmd_pkg::SECOND_CELL) begin : g_second
        assign carry_in[i] = cfg[lcmd_pkg::F_FAST_FB] ? cell_q[i] : carry_in_s;
        assign casc_in[i]  = casc_in_s;
      end else begin : g_rest
        assign carry_in[i] = carry_out[i-1];
        assign casc_in[i]  = casc_out[i-1];
      end

      // inactive lines read high; per-register line choice
      assign aclr_n[i] = ~chip_clr &
                         ~(cfg[lcmd_pkg::F_ACLR_EN] &
                           ~(cfg[lcmd_pkg::F_ACLR_SEL_B] ? line_r[1] : line_r[0]));

      // preset is the clear seen through inverted input and output
      assign cell_q[i] = st_r ^ cfg[lcmd_pkg::F_PRESET];

      // data b gives way to own-output feedback except in the second cell
      // counter control always rides on data a
      assign ctrl     = in_a[i];
      assign load_val = (i != lcmd_pkg::SECOND_CELL && cfg[lcmd_pkg::F_LOAD_HOLD]) ?
                        cell_q[i] : in_b[i];

      always_comb begin
        // the seven cell inputs steered per mode
        // third lookup input from data c or carry
        lut_c        = cfg[lcmd_pkg::F_C_FROM_CARRY] ? carry_in[i] : in_c[i];
        idx4         = {in_d[i], lut_c, in_b[i], in_a[i]};
        idx3         = {carry_in[i], in_b[i], in_a[i]};
        carry_out[i] = 1'b0;
        cell_val[i]  = lut[idx4];
        d_val        = lut[idx4];
        unique case (mode)
          lcmd_pkg::LCMD_ARITH: begin
            // sum lookup of carry, a, b
            d_val        = lut[idx3];
            // carry lookup of the same three
            carry_out[i] = lut[lcmd_pkg::HALF_LUT_W + 32'(idx3)];
          end
          lcmd_pkg::LCMD_COUNTER: begin
            idx3 = {carry_in[i], ctrl, cell_q[i]};
            // up/down mode: up when data a high, down when low; otherwise data a enables an up count
            if (cfg[lcmd_pkg::F_CTRL_UPDN]) begin
              d_val        = lcmd_pkg::CNT_UPDN_DATA[idx3];
              carry_out[i] = lcmd_pkg::CNT_UPDN_CARRY[idx3];
            end else begin
              d_val        = lcmd_pkg::CNT_EN_DATA[idx3];
              carry_out[i] = lcmd_pkg::CNT_EN_CARRY[idx3];
            end
          end
          default: begin
            d_val = lut[idx4];
          end
        endcase
        // arithmetic keeps the cascade usable beside the carry
        if (cfg[lcmd_pkg::F_CASC_EN]) begin
          d_val = d_val & casc_in[i];
        end
        cell_val[i] = d_val;
        casc_out[i] = (i == lcmd_pkg::FIRST_CELL) ? 1'b1 : d_val;
        if (i == lcmd_pkg::FIRST_CELL) begin
          carry_out[i] = 1'b0;
        end
      end

      always_comb begin
        st_nxt = cell_q[i];
        if (mode == lcmd_pkg::LCMD_COUNTER) begin
          // group-wide controls; they override the cascade value
          // selector for load, AND stage for clear; clear wins
          // load of own output holds the count
          st_nxt = (sload ? load_val : cell_val[i]) & ~sclr;
        end else begin
          // flip-flop flavours, second input on data c
          unique case (ff)
            lcmd_pkg::LCMD_FF_D:  st_nxt = cell_val[i];
            lcmd_pkg::LCMD_FF_T:  st_nxt = cell_q[i] ^ cell_val[i];
            lcmd_pkg::LCMD_FF_JK: st_nxt = (cell_val[i] & ~cell_q[i]) |
                                           (~in_c[i] & cell_q[i]);
            lcmd_pkg::LCMD_FF_SR: st_nxt = cell_val[i] | (~in_c[i] & cell_q[i]);
          endcase
        end
      end

      // chip reset reaches every cell through the clear
      // stored bit cleared, so preset cells read one
      always_ff @(posedge REF_CLK or negedge aclr_n[i]) begin
        if (!aclr_n[i]) begin
          st_r <= 1'b0;
        end else if (!RST_N) begin
          st_r <= 1'b0;
        end else begin
          st_r <= st_nxt ^ cfg[lcmd_pkg::F_PRESET];
        end
      end

      // bypass gives the lookup straight to the output in every mode but counter
      always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
          CELL_OUT[i] <= 1'b0;
        end else if (cfg[lcmd_pkg::F_BYPASS] && mode != lcmd_pkg::LCMD_COUNTER) begin
          CELL_OUT[i] <= cell_val[i];
        end else begin
          CELL_OUT[i] <= cell_q[i];
        end
      end

      // contention detect: another enabled driver below this one
      assign tri_oe[i] = global_r[lcmd_pkg::G_TRI_OE_LO + i];
      if (i == 0) begin : g_m0
        assign tri_multi[i] = 1'b0;
      end else begin : g_mn
        assign tri_multi[i] = tri_multi[i-1] | (tri_oe[i] & |tri_oe[i-1:0]);
      end
    end
  endgenerate


  // selector replaces a real tri-state bus; no float, no fight
  // contention found by a ripple chain in which each cell also ORs every enable below it
  always_comb begin
    if (tri_oe == '0) begin
      tri_nxt = 1'b1;
    end else if (tri_multi[NC-1]) begin
      tri_nxt = 1'b0;
    end else begin
      tri_nxt = |(tri_oe & CELL_OUT);
    end
  end


  // chain ends registered so the next group sees clean edges
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      TRI_BUS_OUT <= 1'b1;
      CARRY_OUT   <= 1'b0;
      CASCADE_OUT <= 1'b1;
    end else begin
      TRI_BUS_OUT <= tri_nxt;
      CARRY_OUT   <= carry_out[lcmd_pkg::LAST_CELL];
      CASCADE_OUT <= casc_out[lcmd_pkg::LAST_CELL];
    end
  end

endmodule

/* dv/lcmd_group_drv.sv */
`timescale 1ns/1ns
module lcmd_group_drv (
  // clock
  input  wire logic       clk,
  // levels wanted by the bench: chip_n, line_b_n, line_a_n, cascade, carry, load, clear
  input  wire logic [6:0] req,
  // group-wide lines and chain inputs
  output logic      [6:0] grp
);
  initial grp = 7'h78;
  // one line per group
  // changes only just after an edge, like any neighbour cell
  always @(posedge clk) begin
    grp <= req;
  end
endmodule

/* dv/lcmd_cell_group_sva.sv */
`timescale 1ns/1ns
module lcmd_cell_group_sva (
  // clock and reset
  input wire logic                            REF_CLK,
  input wire logic                            RST_N,
  // bus
  input wire logic [lcmd_pkg::ADDR_W-1:0]     AVS_ADDRESS,
  input wire logic                            AVS_READ,
  input wire logic                            AVS_WRITE,
  input wire logic [lcmd_pkg::DATA_W-1:0]     AVS_READDATA,
  input wire logic                            AVS_WAITREQUEST,
  // results
  input wire logic [lcmd_pkg::NUM_CELLS-1:0]  CELL_OUT,
  input wire logic                            CARRY_OUT,
  input wire logic                            CASCADE_OUT,
  input wire logic                            TRI_BUS_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic req;
  logic ans;
  assign req = AVS_READ | AVS_WRITE;
  assign ans = AVS_READ & !AVS_WAITREQUEST;

  AST_WAIT_START: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
    else $error("new request answered without a wait cycle");
  AST_ONE_WAIT: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("more than one wait cycle");
  AST_IDLE_NO_WAIT: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest high with no request");
  AST_UNMAPPED_RD: assert property (ans && AVS_ADDRESS >= 4'hC |-> AVS_READDATA == lcmd_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");
  AST_RESET_OUT: assert property ($rose(RST_N) |-> CELL_OUT == '0 && !CARRY_OUT && CASCADE_OUT && TRI_BUS_OUT)
    else $error("outputs wrong after reset");
  AST_RD_HOLD: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without a read");
  AST_STATUS_CELLS: assert property (ans && AVS_ADDRESS == lcmd_pkg::REG_STATUS |-> AVS_READDATA[9:0] == $past(CELL_OUT))
    else $error("status cell bits differ from outputs");
  AST_STATUS_CHAIN: assert property (ans && AVS_ADDRESS == lcmd_pkg::REG_STATUS |->
    AVS_READDATA[31:10] == {13'h0000, $past(TRI_BUS_OUT), $past(CASCADE_OUT), $past(CARRY_OUT), 6'h00})
    else $error("status chain bits wrong");
  AST_CFG_RESERVED: assert property (ans && AVS_ADDRESS < 4'hA |-> (AVS_READDATA & ~lcmd_pkg::CELL_CFG_MASK) == '0)
    else $error("reserved cell config bits read back");

  cover property (ans && AVS_ADDRESS == lcmd_pkg::REG_STATUS);
  cover property ($rose(CARRY_OUT));
  cover property ($fell(TRI_BUS_OUT));
endmodule

bind lcmd_cell_group lcmd_cell_group_sva u_sva (
  .REF_CLK, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA, .AVS_WAITREQUEST,
  .CELL_OUT, .CARRY_OUT, .CASCADE_OUT, .TRI_BUS_OUT);

/* dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, rq;
  logic        wreq, wq;
  logic [9:0]  in_a = 10'h000, in_b = 10'h000, in_c = 10'h000, in_d = 10'h000;
  logic [6:0]  req = 7'h78;
  logic [6:0]  grp;
  logic [9:0]  cell_out;
  logic        carry_out, casc_out, tri_out;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  lcmd_group_drv u_drv (.clk(clk), .req(req), .grp(grp));
  lcmd_cell_group u_dut (
    .REF_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .CELL_IN_A(in_a), .CELL_IN_B(in_b), .CELL_IN_C(in_c), .CELL_IN_D(in_d),
    .GROUP_CTRL_LINE_A_N(grp[4]), .GROUP_CTRL_LINE_B_N(grp[5]), .CHIP_RESET_N(grp[6]),
    .GROUP_SYNC_CLEAR(grp[0]), .GROUP_SYNC_LOAD(grp[1]), .CARRY_IN(grp[2]), .CASCADE_IN(grp[3]),
    .CELL_OUT(cell_out), .CARRY_OUT(carry_out), .CASCADE_OUT(casc_out), .TRI_BUS_OUT(tri_out));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; read data taken there
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      wq = wreq;
      rq = rdat;
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) n_mismatch++;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    cmp(what, exp, rq);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_regs();
    rd_chk("status", 4'hB, 32'h0004_0000);
    rd_chk("cfg3", 4'h3, 32'h0000_0000);
    xfer(1'b1, 4'hA, 32'hFFFF_FFFF);
    rd_chk("global", 4'hA, 32'h03FF_0003);
    xfer(1'b1, 4'hA, 32'h0000_0000);
    xfer(1'b1, 4'h9, 32'hFFFF_FFFF);
    rd_chk("cfg9", 4'h9, 32'h1FFF_FFFF);
    xfer(1'b1, 4'h9, 32'h0000_0000);
    rd_chk("cfg9 cleared", 4'h9, 32'h0000_0000);
    xfer(1'b1, 4'hD, 32'hFFFF_FFFF);
    rd_chk("unmapped", 4'hD, 32'h0000_0000);
  endtask

  task automatic t_normal();
    xfer(1'b1, 4'h2, 32'h0010_8000);
    @(posedge clk);
    in_a <= 10'h004;
    in_b <= 10'h004;
    in_c <= 10'h004;
    in_d <= 10'h004;
    settle(5);
    cmp("and4 high", 32'h0000_0004, {22'h0, cell_out});
    @(posedge clk);
    in_d <= 10'h000;
    settle(5);
    cmp("and4 low", 32'h0000_0000, {22'h0, cell_out});
  endtask

  task automatic t_arith();
    logic [8:0] av[2] = '{9'h1FF, 9'h0AA};
    logic [8:0] bv[2] = '{9'h000, 9'h055};
    logic       cv[2] = '{1'b1, 1'b0};
    logic [9:0] s;
    for (int i = 1; i < 10; i++) xfer(1'b1, i[3:0], 32'h0011_E896);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      in_a <= {av[k], 1'b0};
      in_b <= {bv[k], 1'b0};
      req[2] <= cv[k];
      settle(6);
      s = av[k] + bv[k] + cv[k];
      cmp("sum", {22'h0, s[8:0], 1'b0}, {22'h0, cell_out});
      cmp("carry", {31'h0, s[9]}, {31'h0, carry_out});
    end
  endtask

  task automatic t_counter();
    for (int i = 1; i < 10; i++) xfer(1'b1, i[3:0], (i < 5) ? 32'h0003_0000 : 32'h0000_0000);
    @(posedge clk);
    in_a <= 10'h000;
    in_b <= 10'h014;
    req[2:0] <= 3'b111;
    settle(8);
    cmp("clear with load", 32'h0000_0000, {22'h0, cell_out});
    @(posedge clk);
    req[0] <= 1'b0;
    settle(8);
    cmp("load", 32'h0000_0014, {22'h0, cell_out});
    @(posedge clk);
    req[1] <= 1'b0;
    // pins one edge later so both reach the cells together
    @(posedge clk);
    in_a <= 10'h01E;
    repeat (5) @(posedge clk);
    in_a <= 10'h000;
    settle(8);
    cmp("count up", 32'h0000_001E, {22'h0, cell_out});
    @(posedge clk);
    req[2] <= 1'b0;
    for (int i = 1; i < 5; i++) xfer(1'b1, i[3:0], 32'h0203_0000);
    @(posedge clk);
    req[2] <= 1'b1;
    repeat (3) @(posedge clk);
    req[2] <= 1'b0;
    settle(8);
    cmp("count down", 32'h0000_0018, {22'h0, cell_out});
  endtask

  task automatic t_async();
    xfer(1'b1, 4'h5, 32'h0140_0000);
    xfer(1'b1, 4'hA, 32'h0000_0001);
    @(posedge clk);
    req[6] <= 1'b0;
    settle(5);
    cmp("chip reset", 32'h0000_0020, {22'h0, cell_out});
    @(posedge clk);
    req[6] <= 1'b1;
    settle(6);
    cmp("after chip reset", 32'h0000_0000, {22'h0, cell_out});
    @(posedge clk);
    req[5] <= 1'b0;
    settle(5);
    cmp("other line", 32'h0000_0000, {22'h0, cell_out});
    @(posedge clk);
    req[5:4] <= 2'b10;
    settle(5);
    cmp("own line", 32'h0000_0020, {22'h0, cell_out});
  endtask

  task automatic t_tri();
    logic [31:0] en[4] = '{32'h0020_0000, 32'h0022_0000, 32'h0002_0000, 32'h0000_0000};
    logic        ex[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 4'hA, en[k]);
      settle(4);
      cmp("tri bus", {31'h0, ex[k]}, {31'h0, tri_out});
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_normal();
    t_arith();
    t_counter();
    t_async();
    t_tri();
    complete_run();
  end
endmodule
